// ### hw/cib_consts.vh
// register map, field positions, reset values and axi answers for the can irq block
`ifndef CIB_CONSTS_VH
`define CIB_CONSTS_VH
// register indices; byte address is four times the index
`define CIB_IDX_IR 8'h03
`define CIB_IDX_IER 8'h04
`define CIB_IDX_RIL 8'h05
`define CIB_IDX_BIT_TIMING_PRESCALE_JUMP 8'h06
`define CIB_IDX_MODE 8'h10
`define CIB_IDX_CMD 8'h11
`define CIB_IDX_STAT 8'h12
// flag and enable bit positions
`define CIB_BEI 7
`define CIB_ALI 6
`define CIB_EPI 5
`define CIB_WUI 4
`define CIB_DOI 3
`define CIB_EI 2
`define CIB_TI 1
`define CIB_RI 0
// mode and command bits
`define CIB_MODE_RST 0
`define CIB_MODE_SLEEP 1
`define CIB_CMD_RRB 0
// reset values
`define CIB_RST_IER 8'h00
`define CIB_RST_RIL 8'h00
`define CIB_RST_BIT_TIMING_PRESCALE_JUMP 8'h00
`define CIB_RST_MODE 2'h1
// axi answers
`define CIB_RESP_OKAY 2'h0
`define CIB_RESP_DECERR 2'h3
`endif

// ### hw/cib_top.v
// can interrupt enable, receive level and prescaler/jump-width logic
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cib_consts.vh"

module cib_top (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// axi4-lite write address and data
	input wire [11:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// axi4-lite read
	input wire [11:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// events and status from the protocol engine
	input wire bus_err_i,
	input wire arb_lost_i,
	input wire err_passive_i,
	input wire wake_i,
	input wire bus_busy_i,
	input wire overrun_i,
	input wire err_status_i,
	input wire bus_status_i,
	input wire tx_buf_free_i,
	// completed receptions into the message fifo
	input wire rx_msg_done_i,
	input wire rx_hi_prio_i,
	input wire [6:0] rx_msg_bytes_i,
	input wire [6:0] rx_rel_bytes_i,
	// bit timing inputs
	input wire [5:0] bit_len_i,
	input wire resync_edge_i,
	input wire [4:0] phase_err_i,
	// outputs
	output wire int_n_o,
	output wire reset_mode_o,
	output wire sleep_o,
	output wire rx_release_o,
	output wire [5:0] baud_prescaler_o,
	output wire [1:0] resync_jump_width_o,
	output wire scl_tick_o,
	output wire bit_start_o
);

	// register index from a byte address
	function [7:0] cib_idx;
		input [11:0] addr;
		begin
			cib_idx = addr[9:2];
		end
	endfunction

	// magnitude of a signed phase error, clamped to the jump width
	function [2:0] cib_clamp;
		input [4:0] err;
		input [2:0] lim;
		reg [4:0] m;
		begin
			m = err[4] ? (~err + 5'h01) : err;
			cib_clamp = (m > {2'b00, lim}) ? lim : m[2:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// declarations

	reg [7:0] ier_q;
	reg [7:0] ril_q;
	reg [7:0] bit_timing_prescale_jump_q;
	reg [1:0] mode_q;
	reg [7:0] ir_q;
	reg [7:0] ir_d;
	reg int_n_q;
	reg rel_q;
	reg aw_have_q;
	reg w_have_q;
	reg aw_rdy_q;
	reg w_rdy_q;
	reg ar_rdy_q;
	reg [2:0] jump_amt;
	reg [11:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg [6:0] msgs_q;
	reg [6:0] bytes_q;
	reg [6:0] msgs_d;
	reg [6:0] bytes_d;
	reg ep_q;
	reg ov_q;
	reg es_q;
	reg bs_q;
	reg tb_q;
	reg [6:0] pre_q;
	reg scl_q;
	reg [5:0] qcnt_q;
	reg [5:0] adj_len_q;
	reg bit_start_q;
	reg [7:0] rd_val;
	reg rd_ok;
	wire aw_hs;
	wire w_hs;
	wire ar_hs;
	wire wr_go;
	wire [7:0] wr_idx;
	wire wr_lane;
	wire wr_ier;
	wire wr_ril;
	wire wr_btr;
	wire wr_mode;
	wire wr_cmd;
	wire wr_map;
	wire rd_ir;
	wire sleep_try;
	wire sleep_refused;
	wire rel_go;
	wire rx_lvl_hit;
	wire [1:0] resync_jump_width;
	wire [2:0] sjw_q;
	wire [5:0] len_eff;

	////////////////////////////////////////////////////////////////////
	// axi4-lite handshakes; one write and one read in flight

	assign aw_hs = s_axi_awvalid_i & aw_rdy_q;
	assign w_hs = s_axi_wvalid_i & w_rdy_q;
	assign ar_hs = s_axi_arvalid_i & ar_rdy_q;
	assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_idx = cib_idx(awaddr_q);
	// all registers are eight bits wide, so only lane 0 writes
	assign wr_lane = wr_go & wstrb_q[0];
	assign wr_ier = wr_lane & (wr_idx == `CIB_IDX_IER);
	assign wr_ril = wr_lane & (wr_idx == `CIB_IDX_RIL);
	assign wr_btr = wr_lane & (wr_idx == `CIB_IDX_BIT_TIMING_PRESCALE_JUMP)
		& mode_q[`CIB_MODE_RST];
	assign wr_mode = wr_lane & (wr_idx == `CIB_IDX_MODE);
	assign wr_cmd = wr_lane & (wr_idx == `CIB_IDX_CMD);
	assign wr_map = (wr_idx == `CIB_IDX_IR) | (wr_idx == `CIB_IDX_IER)
		| (wr_idx == `CIB_IDX_RIL) | (wr_idx == `CIB_IDX_BIT_TIMING_PRESCALE_JUMP)
		| (wr_idx == `CIB_IDX_MODE) | (wr_idx == `CIB_IDX_CMD)
		| (wr_idx == `CIB_IDX_STAT);
	assign rd_ir = ar_hs & (cib_idx(s_axi_araddr_i) == `CIB_IDX_IR);

	// address and data latch independently, in either order
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `CIB_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_have_q <= 1'b1;
				aw_rdy_q <= 1'b0;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				w_have_q <= 1'b1;
				w_rdy_q <= 1'b0;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_map ? `CIB_RESP_OKAY
					: `CIB_RESP_DECERR;
			end else if (bvalid_q & s_axi_bready_i) begin
				bvalid_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q <= 1'b1;
			end
		end
	end

	// read mux; reserved upper bits read as zero
	always @* begin
		rd_val = 8'h00;
		rd_ok = 1'b1;
		case (cib_idx(s_axi_araddr_i))
			`CIB_IDX_IR: rd_val = ir_q;
			`CIB_IDX_IER: rd_val = ier_q;
			`CIB_IDX_RIL: rd_val = ril_q;
			`CIB_IDX_BIT_TIMING_PRESCALE_JUMP: rd_val = bit_timing_prescale_jump_q;
			`CIB_IDX_MODE: rd_val = {6'h00, mode_q};
			`CIB_IDX_CMD: rd_val = 8'h00;
			`CIB_IDX_STAT: rd_val = {1'b0, msgs_q};
			default: rd_ok = 1'b0;
		endcase
	end

	// read data is captured at the address handshake
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			ar_rdy_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CIB_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			ar_rdy_q <= 1'b0;
			rdata_q <= {24'h00_0000, rd_val};
			rresp_q <= rd_ok ? `CIB_RESP_OKAY : `CIB_RESP_DECERR;
		end else if (rvalid_q & s_axi_rready_i) begin
			rvalid_q <= 1'b0;
			ar_rdy_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers

	// a sleep request is refused while the bus is busy or a flag waits
	assign sleep_try = wr_mode & wdata_q[`CIB_MODE_SLEEP]
		& ~mode_q[`CIB_MODE_SLEEP];
	assign sleep_refused = sleep_try & (bus_busy_i | (|ir_q));

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ier_q <= `CIB_RST_IER;
			ril_q <= `CIB_RST_RIL;
			bit_timing_prescale_jump_q <= `CIB_RST_BIT_TIMING_PRESCALE_JUMP;
			mode_q <= `CIB_RST_MODE;
			rel_q <= 1'b0;
		end else begin
			if (wr_ier)
				ier_q <= wdata_q[7:0];
			if (wr_ril)
				ril_q <= wdata_q[7:0];
			// operating-mode writes are dropped, answer stays okay
			if (wr_btr)
				bit_timing_prescale_jump_q <= wdata_q[7:0];
			if (wr_mode) begin
				mode_q[`CIB_MODE_RST] <= wdata_q[`CIB_MODE_RST];
				if (!sleep_refused)
					mode_q[`CIB_MODE_SLEEP] <=
						wdata_q[`CIB_MODE_SLEEP];
			end else if (wake_i & mode_q[`CIB_MODE_SLEEP]) begin
				mode_q[`CIB_MODE_SLEEP] <= 1'b0;
			end
			rel_q <= rel_go;
		end
	end

	////////////////////////////////////////////////////////////////////
	// receive fifo accounting; only complete messages count

	assign rel_go = wr_cmd & wdata_q[`CIB_CMD_RRB] & (msgs_q != 7'h00);

	always @* begin
		msgs_d = msgs_q;
		bytes_d = bytes_q;
		if (rx_msg_done_i) begin
			msgs_d = msgs_d + 7'h01;
			bytes_d = bytes_d + rx_msg_bytes_i;
		end
		if (rel_go) begin
			msgs_d = msgs_d - 7'h01;
			bytes_d = bytes_d - rx_rel_bytes_i;
		end
		// a reset-mode fifo is empty
		if (mode_q[`CIB_MODE_RST]) begin
			msgs_d = 7'h00;
			bytes_d = 7'h00;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			msgs_q <= 7'h00;
			bytes_q <= 7'h00;
		end else begin
			msgs_q <= msgs_d;
			bytes_q <= bytes_d;
		end
	end

	// level zero degenerates to any whole message present
	assign rx_lvl_hit = (msgs_d != 7'h00)
		& ({1'b0, bytes_d} > ril_q);

	////////////////////////////////////////////////////////////////////
	// interrupt flags; a new event in a clearing read still lands

	always @* begin
		ir_d = ir_q;
		if (rd_ir)
			ir_d[7:1] = 7'h00;
		if (ier_q[`CIB_BEI] & bus_err_i)
			ir_d[`CIB_BEI] = 1'b1;
		if (ier_q[`CIB_ALI] & arb_lost_i)
			ir_d[`CIB_ALI] = 1'b1;
		if (ier_q[`CIB_EPI] & (err_passive_i ^ ep_q))
			ir_d[`CIB_EPI] = 1'b1;
		if (ier_q[`CIB_WUI] & ((wake_i & mode_q[`CIB_MODE_SLEEP])
			| sleep_refused))
			ir_d[`CIB_WUI] = 1'b1;
		if (ier_q[`CIB_DOI] & overrun_i & ~ov_q)
			ir_d[`CIB_DOI] = 1'b1;
		if (ier_q[`CIB_EI] & ((err_status_i ^ es_q)
			| (bus_status_i ^ bs_q)))
			ir_d[`CIB_EI] = 1'b1;
		if (ier_q[`CIB_TI] & tx_buf_free_i & ~tb_q)
			ir_d[`CIB_TI] = 1'b1;
		// release drops the flag; it returns if a message is left
		if (rel_go)
			ir_d[`CIB_RI] = msgs_d != 7'h00;
		if (rx_lvl_hit | (rx_msg_done_i & rx_hi_prio_i))
			ir_d[`CIB_RI] = 1'b1;
		// the enable masks the receive flag at once
		if (!ier_q[`CIB_RI])
			ir_d[`CIB_RI] = 1'b0;
	end

	// previous levels for edge detection on synchronous status
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ir_q <= 8'h00;
			int_n_q <= 1'b1;
			ep_q <= 1'b0;
			ov_q <= 1'b0;
			es_q <= 1'b0;
			bs_q <= 1'b0;
			tb_q <= 1'b1;
		end else begin
			ir_q <= ir_d;
			int_n_q <= ~(|ir_d);
			ep_q <= err_passive_i;
			ov_q <= overrun_i;
			es_q <= err_status_i;
			bs_q <= bus_status_i;
			tb_q <= tx_buf_free_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// quantum prescaler: one tick every 2*(prescaler+1) clocks

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q <= 7'h00;
			scl_q <= 1'b0;
		end else if (pre_q >= {bit_timing_prescale_jump_q[5:0], 1'b1}) begin
			pre_q <= 7'h00;
			scl_q <= 1'b1;
		end else begin
			pre_q <= pre_q + 7'h01;
			scl_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bit timer with resynchronisation

	// phase error is signed quanta: positive lengthens the bit
	assign resync_jump_width = bit_timing_prescale_jump_q[7:6];
	assign sjw_q = {1'b0, resync_jump_width} + 3'h1;
	// the jump is clamped; shortening is capped the same way
	assign len_eff = adj_len_q;

	always @* begin
		jump_amt = cib_clamp(phase_err_i, sjw_q);
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			qcnt_q <= 6'h00;
			adj_len_q <= 6'h00;
			bit_start_q <= 1'b0;
		end else begin
			bit_start_q <= 1'b0;
			if (resync_edge_i) begin
				// every edge retunes the running bit
				if (phase_err_i[4])
					adj_len_q <= bit_len_i - {3'h0, jump_amt};
				else
					adj_len_q <= bit_len_i + {3'h0, jump_amt};
			end else if (scl_q) begin
				if (qcnt_q + 6'h01 >= len_eff) begin
					qcnt_q <= 6'h00;
					bit_start_q <= 1'b1;
					adj_len_q <= bit_len_i;
				end else begin
					qcnt_q <= qcnt_q + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready_o = aw_rdy_q;
	assign s_axi_wready_o = w_rdy_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_arready_o = ar_rdy_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign int_n_o = int_n_q;
	assign reset_mode_o = mode_q[`CIB_MODE_RST];
	assign sleep_o = mode_q[`CIB_MODE_SLEEP];
	assign rx_release_o = rel_q;
	assign baud_prescaler_o = bit_timing_prescale_jump_q[5:0];
	assign resync_jump_width_o = bit_timing_prescale_jump_q[7:6];
	assign scl_tick_o = scl_q;
	assign bit_start_o = bit_start_q;

endmodule

// ### verif/cib_engine_model.sv
// protocol engine stand-in: event sources and completed receptions
`timescale 1ns/1ps
module cib_engine_model (
	// clock
	input wire clk_i,
	// event lines and byte count of the latest message
	output logic [7:0] ev_o,
	output logic [6:0] nb_o
);

// tx buffer starts free, so its first event needs a drop first
initial begin
	ev_o = 8'h20;
	nb_o = 7'h00;
end

////////////////////////////////////////////////////////////////////////////
// one event of the source behind flag bit i; pulses last one cycle
task src(input int i);
	@(posedge clk_i);
	case (i)
	7: ev_o[0] <= 1'b1;
	6: ev_o[1] <= 1'b1;
	5: ev_o[2] <= ~ev_o[2];
	3: ev_o[3] <= 1'b1;
	2: ev_o[4] <= ~ev_o[4];
	default: ev_o[5] <= 1'b0;
	endcase
	@(posedge clk_i);
	ev_o <= {ev_o[7:6], 1'b1, ev_o[4], 1'b0, ev_o[2], 2'b00};
endtask

// one stored message; the count stays for the later release
task msg(input [6:0] n, input hi);
	@(posedge clk_i);
	ev_o[7:6] <= {hi, 1'b1};
	nb_o <= n;
	@(posedge clk_i);
	ev_o[7:6] <= 2'b00;
endtask
endmodule

// ### verif/cib_monitor.sv
// port checker for the can irq block
`timescale 1ns/1ps
module cib_monitor (
	// clock, reset and bus
	input wire clk_i,
	input wire rst_i,
	input wire s_axi_awready_o,
	input wire s_axi_wready_o,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire [31:0] s_axi_rdata_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// status and timing
	input wire bus_busy_i,
	input wire sleep_o,
	input wire reset_mode_o,
	input wire rx_release_o,
	input wire [5:0] baud_prescaler_o,
	input wire [1:0] resync_jump_width_o,
	input wire scl_tick_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
logic [7:0] gap_q;
logic [5:0] p_q;
logic armed_q;

sequence s_rd;
	s_axi_arvalid_i && s_axi_arready_o;
endsequence

////////////////////////////////////////////////////////////////////////////
// cycles since the last tick; a prescaler change disarms the period check
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		gap_q <= 8'h00;
		p_q <= 6'h00;
		armed_q <= 1'b0;
	end else begin
		gap_q <= scl_tick_o ? 8'h00 : gap_q + 8'h01;
		p_q <= baud_prescaler_o;
		armed_q <= (armed_q | scl_tick_o) & (baud_prescaler_o == p_q);
	end
end

////////////////////////////////////////////////////////////////////////////
a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
	s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
	s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
a_read_answer: assert property (s_rd |=> s_axi_rvalid_o)
	else $error("read not answered");
a_upper_zero: assert property (s_axi_rvalid_o |->
	s_axi_rdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
a_write_refuse: assert property (s_axi_bvalid_o |->
	!s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
a_timing_locked: assert property (
	!reset_mode_o |=> $stable({resync_jump_width_o, baud_prescaler_o}))
	else $error("timing changed in operating mode");
a_sleep_busy: assert property (bus_busy_i |=> !$rose(sleep_o))
	else $error("sleep entered while busy");
a_release_pulse: assert property (rx_release_o |=> !rx_release_o)
	else $error("release pulse too long");
a_tick_period: assert property (
	scl_tick_o && armed_q && baud_prescaler_o == p_q |->
	gap_q == {1'b0, baud_prescaler_o, 1'b1}) else $error("tick period");
endmodule

bind cib_top cib_monitor u_mon (.clk_i, .rst_i, .s_axi_awready_o,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .bus_busy_i, .sleep_o, .reset_mode_o, .rx_release_o,
	.baud_prescaler_o, .resync_jump_width_o, .scl_tick_o);

// ### verif/cib_tb.sv
// testbench for the can irq block
`timescale 1ns/1ps
module tb;
localparam [11:0] A_FLAG = 12'h00c;
localparam [11:0] A_EN = 12'h010;
localparam [11:0] A_LVL = 12'h014;
localparam [11:0] A_BT = 12'h018;
localparam [11:0] A_MODE = 12'h040;
localparam [11:0] A_CMD = 12'h044;
logic clk_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
logic bus_busy_i = 0, resync_edge_i = 0;
logic [4:0] phase_err_i = 0;
wire bit_start_o;
logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
logic [31:0] s_axi_wdata_i = 0, rdat;
logic [3:0] s_axi_wstrb_i = 0;
logic [1:0] rsp;
wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
wire s_axi_rvalid_o, int_n_o, reset_mode_o, rx_release_o;
wire [1:0] s_axi_bresp_o, s_axi_rresp_o, resync_jump_width_o;
wire [31:0] s_axi_rdata_o;
wire [5:0] baud_prescaler_o;
wire [7:0] ev;
wire [6:0] nb;
int bad_count = 0, compares = 0;

always #20 clk_i = ~clk_i;

cib_engine_model u_eng (.clk_i, .ev_o(ev), .nb_o(nb));

// wake and bus status stay quiet; resync edge and phase error are driven by the bt task
cib_top u_dut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .bus_err_i(ev[0]),
	.arb_lost_i(ev[1]), .err_passive_i(ev[2]), .wake_i(1'b0), .bus_busy_i,
	.overrun_i(ev[3]), .err_status_i(ev[4]), .bus_status_i(1'b0),
	.tx_buf_free_i(ev[5]), .rx_msg_done_i(ev[6]), .rx_hi_prio_i(ev[7]),
	.rx_msg_bytes_i(nb), .rx_rel_bytes_i(nb), .bit_len_i(6'h0a),
	.resync_edge_i, .phase_err_i, .int_n_o, .reset_mode_o,
	.sleep_o(), .rx_release_o, .baud_prescaler_o, .resync_jump_width_o,
	.scl_tick_o(), .bit_start_o);

////////////////////////////////////////////////////////////////////////////
task chk(input [31:0] g, input [31:0] e);
	compares++;
	if (g !== e) begin
		bad_count++;
		$display("[FAIL] %0t got %h expected %h", $time, g, e);
	end
endtask

// write: both halves offered together, each dropped once taken
task wr(input [11:0] a, input [7:0] d);
	@(posedge clk_i);
	s_axi_awaddr_i <= a;
	s_axi_wdata_i <= {24'h00_0000, d};
	s_axi_wstrb_i <= 4'hf;
	s_axi_awvalid_i <= 1'b1;
	s_axi_wvalid_i <= 1'b1;
	s_axi_bready_i <= 1'b1;
	forever begin
		@(posedge clk_i);
		if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
		if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		if (s_axi_bvalid_o === 1'b1) break;
	end
	s_axi_bready_i <= 1'b0;
endtask

task rd(input [11:0] a, output [31:0] d, output [1:0] r);
	@(posedge clk_i);
	s_axi_araddr_i <= a;
	s_axi_arvalid_i <= 1'b1;
	s_axi_rready_i <= 1'b1;
	forever begin
		@(posedge clk_i);
		if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		if (s_axi_rvalid_o === 1'b1) break;
	end
	d = s_axi_rdata_o;
	r = s_axi_rresp_o;
	s_axi_rready_i <= 1'b0;
endtask

task rc(input [11:0] a, input [7:0] e);
	rd(a, rdat, rsp);
	chk(rdat, {24'h00_0000, e});
endtask

// resync just after a bit start; the bit then spans q quanta of 12 clocks
task bt(input [4:0] pe, input int q);
	int n;
	@(posedge clk_i);
	while (bit_start_o !== 1'b1) @(posedge clk_i);
	resync_edge_i <= 1'b1;
	phase_err_i <= pe;
	n = 0;
	do begin
		@(posedge clk_i);
		resync_edge_i <= 1'b0;
		n++;
	end while (bit_start_o !== 1'b1);
	chk(n, 12 * q);
endtask

// let the event edge and the flag update land
task st;
	repeat (2) @(posedge clk_i);
	#1;
endtask

task end_of_test;
	$display("compares %0d bad_count %0d", compares, bad_count);
	if (bad_count == 0 && compares > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////
// hang guard, generous against roughly twelve hundred cycles of tests
initial begin
	repeat (20000) @(posedge clk_i);
	bad_count++;
	end_of_test;
end

initial begin
	repeat (16) @(posedge clk_i);
	rst_i <= 1'b0;
	#1;
	chk(int_n_o, 1);
	rc(A_EN, 8'h00);
	rc(A_LVL, 8'h00);
	rc(A_BT, 8'h00);
	wr(A_BT, 8'hc5);
	rc(A_BT, 8'hc5);
	chk(baud_prescaler_o, 5);
	chk(resync_jump_width_o, 3);
	repeat (40) @(posedge clk_i);
	wr(A_MODE, 8'h00);
	chk(reset_mode_o, 0);
	wr(A_BT, 8'h12);
	rc(A_BT, 8'hc5);
	wr(A_EN, 8'h5a);
	rc(A_EN, 8'h5a);
	rd(12'h3fc, rdat, rsp);
	chk(rsp, 3);
	chk(rdat, 0);
	// each source alone; bit 4 comes from a refused sleep on a busy bus
	for (int i = 7; i > 0; i--) begin
		wr(A_EN, 8'h01 << i);
		if (i == 4) begin
			bus_busy_i <= 1'b1;
			wr(A_MODE, 8'h02);
			bus_busy_i <= 1'b0;
		end else
			u_eng.src(i);
		st;
		chk(int_n_o, 0);
		rc(A_FLAG, 8'h01 << i);
		rc(A_FLAG, 8'h00);
		chk(int_n_o, 1);
	end
	// sources of bits 7 to 1 except bit 4, with every enable off
	wr(A_EN, 8'h00);
	for (int i = 7; i > 0; i--)
		if (i != 4) u_eng.src(i);
	st;
	chk(int_n_o, 1);
	rc(A_FLAG, 8'h00);
	// receive level, read, release and priority
	wr(A_EN, 8'h01);
	wr(A_LVL, 8'h0a);
	u_eng.msg(7'd8, 1'b0);
	st;
	chk(int_n_o, 1);
	u_eng.msg(7'd8, 1'b0);
	st;
	chk(int_n_o, 0);
	rc(A_FLAG, 8'h01);
	rc(A_FLAG, 8'h01);
	wr(A_CMD, 8'h01);
	st;
	rc(A_FLAG, 8'h01);
	wr(A_CMD, 8'h01);
	st;
	rc(A_FLAG, 8'h00);
	chk(int_n_o, 1);
	u_eng.msg(7'd4, 1'b1);
	st;
	chk(int_n_o, 0);
	wr(A_EN, 8'h00);
	#1;
	chk(int_n_o, 1);
	rc(A_FLAG, 8'h00);
	wr(A_CMD, 8'h01);
	wr(A_LVL, 8'h00);
	wr(A_EN, 8'h01);
	u_eng.msg(7'd1, 1'b0);
	st;
	chk(int_n_o, 0);
	wr(A_CMD, 8'h01);
	st;
	chk(int_n_o, 1);
	// prescaler 5 and jump width 3 still stand from reset mode
	bt(5'h00, 10);
	bt(5'h02, 12);
	bt(5'h07, 14);
	bt(5'h19, 6);
	end_of_test;
end
endmodule
